// ### inc/irq_reset_pkg.sv
// Constants, types and the state record of the interrupt and reset-source unit
package irq_reset_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_PC_MASK = 6'h10;
   localparam logic [5:0] IDX_PC_FLAG = 6'h11;
   localparam logic [5:0] IDX_PC_CTRL = 6'h12;
   localparam logic [5:0] IDX_EXT_EN = 6'h13;
   localparam logic [5:0] IDX_EXT_FLAG = 6'h14;
   localparam logic [5:0] IDX_EXT_SENSE = 6'h15;
   localparam logic [5:0] IDX_SUPPLY = 6'h34;
   localparam logic [5:0] IDX_RESET_CAUSE = 6'h3b;
   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int SUPPLY_FLAG_BIT = 7;
   localparam int SUPPLY_IE_BIT = 6;
   localparam int WD_FLAG_BIT = 3;
   localparam int PIN_FLAG_BIT = 1;
   localparam int POR_FLAG_BIT = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Trigger level select codes
   localparam logic [2:0] LVL_OFF = 3'h0;
   localparam logic [2:0] LVL_POR_LO = 3'h1;
   localparam logic [2:0] LVL_POR_HI = 3'h2;
   localparam logic [2:0] LVL_FLAG_LO = 3'h3;
   localparam logic [2:0] LVL_FLAG_HI = 3'h4;
   ////////////////////////////////////////////////////////////////////////////
   // Sense select codes
   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_ANY = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;
   ////////////////////////////////////////////////////////////////////////////
   // Vector program addresses
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [15:0] VEC_EXT = 16'h0001;
   localparam logic [15:0] VEC_PIN_CHANGE = 16'h0002;
   localparam logic [15:0] VEC_SUPPLY = 16'h0009;
   localparam int VEC_LAST = 10;
   ////////////////////////////////////////////////////////////////////////////
   // Reset values; the power-on flag comes up set
   localparam logic [2:0] RESET_CAUSE_INIT = 3'h1;
   localparam logic [31:0] READ_INIT = 32'h0000_0000;

   typedef enum logic [0:0] {
      BUS_DONE = 1'b0,
      BUS_WAIT = 1'b1
   } bus_state_t;

   typedef struct packed {
      bus_state_t busState;
      logic [31:0] readData;
      logic [2:0] supplyLevel;
      logic supplyIe;
      logic supplyFlag;
      logic supplyPending;
      logic supplyBelowPrev;
      logic [2:0] resetCause;
      logic [1:0] senseSel;
      logic extEnable;
      logic extFlag;
      logic extPinPrev;
      logic pcEnable;
      logic pcFlag;
      logic [3:0] pcMask;
      logic [3:0] pcPrev;
      logic armed;
      logic irqValid;
      logic [15:0] irqVector;
      logic resetReq;
      logic supplyResetReq;
      logic wakeReq;
      logic ioClockEnable;
   } state_t;
endpackage

// ### logic/interrupt_reset_source_unit.sv
// Interrupt vectoring, external and pin-change sensing, supply monitor, reset causes
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// What this block does
// R1: Supply-low flag sets on trigger; clears when disabled or supply recovers.
// R2: With interrupt enable set, each setting of the flag requests a monitor interrupt.
// R3: Software writes zeros into reserved bits 5:3 of the monitor register.
// R4: Level select 000 disables the monitor; codes 101 to 111 are forbidden.
// R5: Levels 001 and 010 request power-on reset and leave the flag clear.
// R6: Levels 011 and 100 set the flag and raise the interrupt if enabled.
// R7: Watchdog reset sets bit 3; power-on reset or writing zero clears it.
// R8: Pin reset sets bit 1; power-on reset or writing zero clears it.
// R9: Power-on reset sets bit 0; only writing zero clears it.
// R10: Bits 7 to 4 and bit 2 of the reset cause register read zero.
// R11: Pin, power-on, supply and watchdog resets share vector 0x0000.
// R12: External pin interrupt vectors to 0x0001, pin change to 0x0002.
// R13: Timer, comparator, watchdog, supply, converter vectors run 0x0003 to 0x000A.
// R14: Pin interrupts fire from pin activity even when pins are driven outputs.
// R15: Pin change fires when any mask-enabled pin of the four toggles.
// R16: Pin-change detection needs no I/O clock and wakes from every sleep mode.
// R17: Enabled level mode keeps requesting while the pin stays low.
// R18: Edge detection on the external pin needs the running I/O clock.
// R19: Low level wakes from any sleep; I/O clock stops except in idle.
// R20: The source holds the level low through start-up to get the interrupt.
// R21: A low level gone before start-up still wakes but gives no interrupt.
// R22: Sense select: 00 low, 01 any change, 10 falling, 11 rising.
// R23: External flag clears on handler or write one; stays zero in level mode.
// R24: Each mask bit enables change detection on its own pin only.
// R25: With several requests pending the lowest vector address is served first.
module interrupt_reset_source_unit
   import irq_reset_pkg::*;
(
   // Clock and power-on reset
   input wire logic clock,
   input wire logic rstn,
   // Avalon-MM slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Pins, seen at the pad whatever their direction
   input wire logic externalIrqPin,
   input wire logic [3:0] pinChangeInputs,
   // Supply comparator and other reset sources
   input wire logic supplyBelow,
   input wire logic pinResetEvent,
   input wire logic watchdogResetEvent,
   // Requests of peripherals: capture, overflow, cmpA, cmpB, comparator, watchdog, converter
   input wire logic [6:0] periphIrq,
   // Core side
   input wire logic irqAck,
   input wire logic sleepActive,
   input wire logic sleepIdle,
   output logic irqValid,
   output logic [15:0] irqVector,
   output logic resetReq,
   output logic supplyResetReq,
   output logic wakeReq,
   output logic ioClockEnable
);

   state_t s;
   state_t n;
   logic [3:0] pcHit;
   logic [VEC_LAST:1] req;
   logic [5:0] idx;

   assign idx = address[7:2];

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin masked toggle; compares pad levels, so output pins count too
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pc
         assign pcHit[gi] = s.pcMask[gi] & (pinChangeInputs[gi] ^ s.pcPrev[gi]); // [R24] [R14]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic for the whole block
   always_comb begin
      logic wrDone;
      logic below;
      logic rise;
      logic edgeHit;
      logic pinLow;
      wrDone = 1'b0;
      below = supplyBelow;
      rise = supplyBelow & ~s.supplyBelowPrev;
      edgeHit = 1'b0;
      pinLow = ~externalIrqPin;
      n = s;
      n.resetReq = 1'b0;
      n.supplyResetReq = 1'b0;
      n.armed = 1'b1;
      n.supplyBelowPrev = below;
      n.extPinPrev = externalIrqPin;
      n.pcPrev = pinChangeInputs;

      // Bus: one wait cycle, then the answer with waitrequest low
      case (s.busState)
         BUS_WAIT: begin
            if (read || write) begin
               n.busState = BUS_DONE;
               n.readData = READ_INIT;
               case (idx)
                  IDX_PC_MASK: n.readData[3:0] = s.pcMask;
                  IDX_PC_FLAG: n.readData[0] = s.pcFlag;
                  IDX_PC_CTRL: n.readData[0] = s.pcEnable;
                  IDX_EXT_EN: n.readData[0] = s.extEnable;
                  IDX_EXT_FLAG: n.readData[0] = s.extFlag;
                  IDX_EXT_SENSE: n.readData[1:0] = s.senseSel;
                  IDX_SUPPLY: begin
                     n.readData[SUPPLY_FLAG_BIT] = s.supplyFlag;
                     n.readData[SUPPLY_IE_BIT] = s.supplyIe;
                     n.readData[2:0] = s.supplyLevel;
                  end
                  IDX_RESET_CAUSE: begin
                     // Unused bits stay at the zero default [R10]
                     n.readData[WD_FLAG_BIT] = s.resetCause[2];
                     n.readData[PIN_FLAG_BIT] = s.resetCause[1];
                     n.readData[POR_FLAG_BIT] = s.resetCause[0];
                  end
                  default: n.readData = READ_INIT;
               endcase
            end
         end
         BUS_DONE: begin
            n.busState = BUS_WAIT;
            wrDone = write & byteenable[0];
         end
         default: n.busState = BUS_WAIT;
      endcase

      // Register writes take effect on the edge where waitrequest is low
      if (wrDone) begin
         case (idx)
            IDX_PC_MASK: n.pcMask = writedata[3:0];
            IDX_PC_FLAG: n.pcFlag = s.pcFlag & ~writedata[0];
            IDX_PC_CTRL: n.pcEnable = writedata[0];
            IDX_EXT_EN: n.extEnable = writedata[0];
            IDX_EXT_FLAG: n.extFlag = s.extFlag & ~writedata[0]; // [R23]
            IDX_EXT_SENSE: n.senseSel = writedata[1:0];
            IDX_SUPPLY: begin
               n.supplyIe = writedata[SUPPLY_IE_BIT];
               // Forbidden codes are refused so the monitor never sits undefined
               if (writedata[2:0] <= LVL_FLAG_HI) begin // [R4]
                  n.supplyLevel = writedata[2:0];
               end
            end
            IDX_RESET_CAUSE: begin
               // Writing zero clears; writing one leaves the flag alone
               n.resetCause[2] = s.resetCause[2] & writedata[WD_FLAG_BIT]; // [R7]
               n.resetCause[1] = s.resetCause[1] & writedata[PIN_FLAG_BIT]; // [R8]
               n.resetCause[0] = s.resetCause[0] & writedata[POR_FLAG_BIT]; // [R9]
            end
            default: n.readData = s.readData;
         endcase
      end

      // Reset causes: set after the clear so a coincident event survives
      if (watchdogResetEvent) begin
         n.resetCause[2] = 1'b1; // [R7]
      end
      if (pinResetEvent) begin
         n.resetCause[1] = 1'b1; // [R8]
      end

      // Supply monitor; level 000 disables everything [R4]
      if (n.supplyLevel == LVL_OFF || !below) begin
         n.supplyFlag = 1'b0; // [R1]
      end
      if (rise && (n.supplyLevel == LVL_POR_LO || n.supplyLevel == LVL_POR_HI)) begin
         n.supplyResetReq = 1'b1; // [R5]
      end
      if (rise && (n.supplyLevel == LVL_FLAG_LO || n.supplyLevel == LVL_FLAG_HI)) begin
         n.supplyFlag = 1'b1; // [R1] [R6]
      end
      if (irqAck && s.irqValid && s.irqVector == VEC_SUPPLY) begin
         n.supplyPending = 1'b0;
      end
      if (n.supplyFlag && !s.supplyFlag && n.supplyIe) begin
         n.supplyPending = 1'b1; // [R2] [R6]
      end

      // External pin edges only count while the I/O clock runs
      case (n.senseSel)
         SENSE_ANY: edgeHit = externalIrqPin ^ s.extPinPrev; // [R22]
         SENSE_FALL: edgeHit = s.extPinPrev & ~externalIrqPin;
         SENSE_RISE: edgeHit = ~s.extPinPrev & externalIrqPin;
         default: edgeHit = 1'b0;
      endcase
      if (irqAck && s.irqValid && s.irqVector == VEC_EXT) begin
         n.extFlag = 1'b0; // [R23]
      end
      if (edgeHit && s.armed && s.ioClockEnable) begin
         n.extFlag = 1'b1; // [R18]
      end
      if (n.senseSel == SENSE_LOW) begin
         n.extFlag = 1'b0; // [R23]
      end

      // Pin change needs no I/O clock, so it also works in deep sleep
      if (irqAck && s.irqValid && s.irqVector == VEC_PIN_CHANGE) begin
         n.pcFlag = 1'b0;
      end
      if (|pcHit && s.armed) begin
         n.pcFlag = 1'b1; // [R15] [R16]
      end

      // Request vector, lowest number first
      req[1] = n.extEnable & ((n.senseSel == SENSE_LOW) ? pinLow : n.extFlag); // [R17] [R21]
      req[2] = n.pcEnable & n.pcFlag;
      req[6:3] = periphIrq[3:0]; // [R13]
      req[7] = periphIrq[4];
      req[8] = periphIrq[5];
      req[9] = n.supplyPending;
      req[10] = periphIrq[6];
      n.irqValid = |req;
      n.irqVector = VEC_RESET;
      for (int v = VEC_LAST; v >= 1; v--) begin
         if (req[v]) begin
            n.irqVector = 16'(v); // [R25] [R12] [R13]
         end
      end

      // Any reset source points the core at the shared reset vector
      if (pinResetEvent || watchdogResetEvent || n.supplyResetReq) begin
         n.resetReq = 1'b1; // [R11]
         n.irqValid = 1'b0;
         n.irqVector = VEC_RESET; // [R11]
      end

      // Wake and I/O clock gating
      n.ioClockEnable = ~sleepActive | sleepIdle; // [R19]
      n.wakeReq = sleepActive & ((n.extEnable & (n.senseSel == SENSE_LOW) & pinLow) // [R19]
                  | (|pcHit) | n.irqValid); // [R16]
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; rstn acts as the power-on reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.busState <= BUS_WAIT;
         s.resetCause <= RESET_CAUSE_INIT; // [R9] [R7] [R8]
         s.ioClockEnable <= 1'b1;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state flops
   assign readdata = s.readData;
   assign waitrequest = s.busState;
   assign irqValid = s.irqValid;
   assign irqVector = s.irqVector;
   assign resetReq = s.resetReq;
   assign supplyResetReq = s.supplyResetReq;
   assign wakeReq = s.wakeReq;
   assign ioClockEnable = s.ioClockEnable;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence flag_level_rise_s;
      $rose(supplyBelow) && (s.supplyLevel == LVL_FLAG_LO || s.supplyLevel == LVL_FLAG_HI)
         && !(s.busState == BUS_DONE && write && idx == IDX_SUPPLY);
   endsequence

   sequence por_level_rise_s;
      $rose(supplyBelow) && (s.supplyLevel == LVL_POR_LO || s.supplyLevel == LVL_POR_HI)
         && !(s.busState == BUS_DONE && write && idx == IDX_SUPPLY);
   endsequence

   supply_flag_set_a: assert property (flag_level_rise_s |=> s.supplyFlag) // [R6]
      else $error("supply flag not set on trigger");
   supply_flag_clr_a: assert property (s.supplyLevel == LVL_OFF |-> !s.supplyFlag) // [R1]
      else $error("supply flag set while monitor disabled");
   supply_irq_a: assert property ($rose(s.supplyFlag) && s.supplyIe && !irqAck
      |-> s.supplyPending ##1 (s.irqValid && s.irqVector <= VEC_SUPPLY)) // [R2]
      else $error("no monitor request after flag set");
   supply_por_a: assert property (por_level_rise_s |=> s.supplyResetReq && !s.supplyFlag
      && s.resetReq && s.irqVector == VEC_RESET) // [R5]
      else $error("por level did not request reset");
   wd_flag_set_a: assert property (watchdogResetEvent |=> s.resetCause[2]) // [R7]
      else $error("watchdog flag not set");
   pin_flag_set_a: assert property (pinResetEvent |=> s.resetCause[1] ##1 s.resetCause[1]
      || $past(write)) // [R8]
      else $error("pin reset flag not set");
   cause_reserved_a: assert property (s.busState == BUS_DONE && read && idx == IDX_RESET_CAUSE
      |-> s.readData[7:4] == 4'h0 && !s.readData[2]) // [R10]
      else $error("reserved reset cause bits nonzero");
   level_flag_zero_a: assert property (s.senseSel == SENSE_LOW |-> !s.extFlag) // [R23]
      else $error("external flag set in level mode");
   level_request_a: assert property (s.extEnable && s.senseSel == SENSE_LOW && !externalIrqPin
      && !pinResetEvent && !watchdogResetEvent && !$rose(supplyBelow)
      && !(s.busState == BUS_DONE && write)
      |=> s.irqValid && s.irqVector == VEC_EXT) // [R17]
      else $error("level mode not requesting");
   edge_gated_a: assert property (!s.ioClockEnable && !s.extFlag && s.senseSel != SENSE_LOW
      && !(s.busState == BUS_DONE && write) |=> !s.extFlag) // [R18]
      else $error("edge caught with I/O clock stopped");
   pc_toggle_a: assert property (s.armed && |pcHit |=> s.pcFlag) // [R15]
      else $error("masked pin change not flagged");
   io_clock_stop_a: assert property (sleepActive && !sleepIdle |=> !s.ioClockEnable) // [R19]
      else $error("I/O clock left running in deep sleep");

endmodule // interrupt_reset_source_unit

// ### testbench/core_model.sv
// Processor core stand-in that takes vectored requests
`timescale 1ns/100ps
module core_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Request side of the unit
   input wire logic irqValid,
   input wire logic [15:0] irqVector,
   output logic irqAck,
   // Bench control and record
   input wire logic acceptOn,
   input wire logic [3:0] lateBy,
   output logic [15:0] lastVector,
   output int takenCount
);
   logic [4:0] holdOff;
   // Ack after lateBy cycles; hold off one more after an ack, though the
   // registered request already drops the acked source at the ack edge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irqAck <= 1'b0;
         holdOff <= 5'h0;
         lastVector <= 16'hffff;
         takenCount <= 0;
      end else if (irqAck) begin
         irqAck <= 1'b0;
         lastVector <= irqVector; // Vector taken at the ack edge
         takenCount <= takenCount + 1;
         holdOff <= {1'b0, lateBy} + 5'h1;
      end else if (!acceptOn || !irqValid) begin
         holdOff <= {1'b0, lateBy};
      end else if (holdOff != 5'h0) begin
         holdOff <= holdOff - 5'h1;
      end else begin
         irqAck <= 1'b1;
      end
   end
endmodule // core_model

// ### testbench/interrupt_reset_source_unit_tb.sv
// Self-checking bench for the interrupt and reset-source unit
`timescale 1ns/100ps
module interrupt_reset_source_unit_tb;
   import irq_reset_pkg::*;
   logic clock, rstn, read, write, externalIrqPin, supplyBelow, pinResetEvent;
   logic watchdogResetEvent, irqAck, sleepActive, sleepIdle, waitrequest, irqValid;
   logic resetReq, supplyResetReq, wakeReq, ioClockEnable, acceptOn;
   logic [7:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable, pinChangeInputs, lateBy;
   logic [6:0] periphIrq;
   logic [15:0] irqVector, lastVector;
   int takenCount, nFail, checkCount, resetPulses, supplyPulses, base;
   logic [15:0] vecTab [7] = '{16'h3, 16'h4, 16'h5, 16'h6, 16'h7, 16'h8, 16'ha};

   interrupt_reset_source_unit dut (.clock(clock), .rstn(rstn), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .externalIrqPin(externalIrqPin),
      .pinChangeInputs(pinChangeInputs), .supplyBelow(supplyBelow),
      .pinResetEvent(pinResetEvent), .watchdogResetEvent(watchdogResetEvent),
      .periphIrq(periphIrq), .irqAck(irqAck), .sleepActive(sleepActive),
      .sleepIdle(sleepIdle), .irqValid(irqValid), .irqVector(irqVector),
      .resetReq(resetReq), .supplyResetReq(supplyResetReq), .wakeReq(wakeReq),
      .ioClockEnable(ioClockEnable));
   core_model core (.clock(clock), .rstn(rstn), .irqValid(irqValid), .irqVector(irqVector),
      .irqAck(irqAck), .acceptOn(acceptOn), .lateBy(lateBy), .lastVector(lastVector),
      .takenCount(takenCount));

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checkCount++;
      if (got !== exp) begin
         nFail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // One bus cycle; request held until waitrequest is seen low
   task automatic busAccess(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
         output logic [31:0] rd);
      int guard;
      @(posedge clock);
      address <= {idx, 2'b00};
      writedata <= {24'h0, wd};
      byteenable <= 4'h1;
      read <= !wr;
      write <= wr;
      guard = 0;
      do begin
         @(posedge clock);
         guard++;
      end while (waitrequest !== 1'b0 && guard < 50);
      check({31'h0, guard >= 50}, 32'h0, "bus timeout");
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] unused;
      busAccess(1'b1, idx, d, unused);
   endtask
   task automatic rdChk(input logic [5:0] idx, input logic [7:0] exp, input string what);
      logic [31:0] d;
      busAccess(1'b0, idx, 8'h0, d);
      check(d, {24'h0, exp}, what);
   endtask
   task automatic req(input logic v, input logic [15:0] vec, input string what);
      check({15'h0, irqValid, irqVector}, {15'h0, v, vec}, what);
   endtask
   task automatic pins(input logic e, input logic [3:0] p);
      @(posedge clock);
      externalIrqPin <= e;
      pinChangeInputs <= p;
      tick(4);
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Reset pulses must show no vectored request
   always @(posedge clock) begin
      if (resetReq === 1'b1) begin
         resetPulses++;
         req(1'b0, VEC_RESET, "reset shows vector");
      end
      if (supplyResetReq === 1'b1) supplyPulses++;
   end
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Hang guard; the sequence needs only a few hundred cycles
   initial begin
      #50000;
      nFail++;
      $display("wrong value at %0t: run did not finish", $time);
      tally_and_finish;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {rstn, read, write, supplyBelow, pinResetEvent, watchdogResetEvent} = 6'h0;
      {sleepActive, sleepIdle, acceptOn, externalIrqPin} = 4'h1;
      {address, writedata, byteenable, pinChangeInputs, lateBy, periphIrq} = 59'h0;
      nFail = 0;
      checkCount = 0;
      resetPulses = 0;
      supplyPulses = 0;
      tick(4);
      rstn <= 1'b1;
      tick(2);
      // Reset causes
      rdChk(IDX_RESET_CAUSE, 8'h01, "cause at power-on");
      rdChk(IDX_SUPPLY, 8'h00, "monitor reset value");
      rdChk(6'h3f, 8'h00, "unmapped read");
      {pinResetEvent, watchdogResetEvent} <= 2'h3;
      tick(1);
      {pinResetEvent, watchdogResetEvent} <= 2'h0;
      tick(3);
      check(resetPulses, 1, "one reset pulse");
      rdChk(IDX_RESET_CAUSE, 8'h0b, "pin and watchdog flags");
      wr(IDX_RESET_CAUSE, 8'hf5);
      rdChk(IDX_RESET_CAUSE, 8'h01, "zero clears, one keeps");
      wr(IDX_RESET_CAUSE, 8'h00);
      rdChk(IDX_RESET_CAUSE, 8'h00, "power-on flag cleared");
      watchdogResetEvent <= 1'b1;
      tick(1);
      watchdogResetEvent <= 1'b0;
      rdChk(IDX_RESET_CAUSE, 8'h08, "watchdog alone");
      rstn <= 1'b0;
      tick(4);
      rstn <= 1'b1;
      tick(2);
      rdChk(IDX_RESET_CAUSE, 8'h01, "power-on clears watchdog");
      // Supply monitor: reset levels, then flag levels; reserved bits written zero
      for (int l = 1; l <= 4; l++) begin
         base = supplyPulses;
         wr(IDX_SUPPLY, 8'h40 | 8'(l));
         supplyBelow <= 1'b1;
         tick(4);
         check(supplyPulses - base, int'(l < 3), "supply reset pulse");
         rdChk(IDX_SUPPLY, (l < 3) ? 8'h41 * 8'(l) - 8'h40 * 8'(l - 1) : 8'hc0 | 8'(l), "flag");
         req(l > 2, (l > 2) ? VEC_SUPPLY : VEC_RESET, "monitor request");
         supplyBelow <= 1'b0;
         tick(4);
         rdChk(IDX_SUPPLY, 8'h40 | 8'(l), "flag clears on recovery");
         acceptOn <= 1'b1;
         tick(12);
         acceptOn <= 1'b0;
         req(1'b0, VEC_RESET, "monitor request taken");
      end
      check(32'(lastVector), 32'(VEC_SUPPLY), "monitor vector");
      wr(IDX_SUPPLY, 8'(LVL_FLAG_HI));
      supplyBelow <= 1'b1;
      tick(4);
      req(1'b0, VEC_RESET, "no request when disabled");
      wr(IDX_SUPPLY, 8'h07);
      rdChk(IDX_SUPPLY, 8'h84, "forbidden level refused");
      wr(IDX_SUPPLY, 8'(LVL_OFF));
      rdChk(IDX_SUPPLY, 8'h00, "disabled clears flag");
      supplyBelow <= 1'b0;
      // External pin: any change, falling, rising with slow core answers
      wr(IDX_EXT_EN, 8'h01);
      acceptOn <= 1'b1;
      for (int s = 1; s <= 3; s++) begin
         wr(IDX_EXT_SENSE, 8'(s));
         lateBy <= 4'(s);
         base = takenCount;
         pins(1'b0, 4'h0);
         tick(12);
         pins(1'b1, 4'h0);
         tick(12);
         check(takenCount - base, (s == 1) ? 2 : 1, "edge count per sense");
         check(32'(lastVector), 32'(VEC_EXT), "external vector");
      end
      acceptOn <= 1'b0;
      wr(IDX_EXT_SENSE, 8'(SENSE_FALL));
      pins(1'b0, 4'h0);
      rdChk(IDX_EXT_FLAG, 8'h01, "external flag set");
      wr(IDX_EXT_FLAG, 8'h01);
      rdChk(IDX_EXT_FLAG, 8'h00, "write one clears");
      wr(IDX_EXT_SENSE, 8'(SENSE_LOW));
      tick(20);
      req(1'b1, VEC_EXT, "level keeps requesting");
      rdChk(IDX_EXT_FLAG, 8'h00, "flag zero in level mode");
      pins(1'b1, 4'h0);
      req(1'b0, VEC_RESET, "level released");
      // Deep sleep: edges unseen, low level and pin change still wake
      {sleepActive, sleepIdle} <= 2'h2;
      wr(IDX_EXT_SENSE, 8'(SENSE_FALL));
      check(32'(ioClockEnable), 32'h0, "io clock stopped");
      pins(1'b0, 4'h0);
      req(1'b0, VEC_RESET, "edge unseen asleep");
      pins(1'b1, 4'h0);
      wr(IDX_EXT_SENSE, 8'(SENSE_LOW));
      pins(1'b0, 4'h0);
      check(32'(wakeReq), 32'h1, "low level wakes");
      pins(1'b1, 4'h0);
      req(1'b0, VEC_RESET, "short low gives no request");
      wr(IDX_EXT_EN, 8'h00);
      wr(IDX_PC_MASK, 8'h04);
      wr(IDX_PC_CTRL, 8'h01);
      pins(1'b1, 4'h4);
      check(32'(wakeReq), 32'h1, "pin change wakes");
      req(1'b1, VEC_PIN_CHANGE, "pin change vector");
      {sleepActive, sleepIdle} <= 2'h0;
      tick(3);
      check(32'(ioClockEnable), 32'h1, "io clock back");
      // Each mask bit gates its own pin only
      for (int i = 0; i < 4; i++) begin
         wr(IDX_PC_FLAG, 8'h01);
         wr(IDX_PC_MASK, 8'h01 << i);
         pins(1'b1, pinChangeInputs ^ ~(4'h1 << i));
         rdChk(IDX_PC_FLAG, 8'h00, "masked pins ignored");
         pins(1'b1, pinChangeInputs ^ (4'h1 << i));
         rdChk(IDX_PC_FLAG, 8'h01, "enabled pin toggles");
      end
      // Vector table and lowest address first; the pin-change flag is still
      // set, so its enable is off here or vector 2 would mask every source
      wr(IDX_PC_CTRL, 8'h00);
      for (int i = 0; i < 7; i++) begin
         periphIrq <= 7'h1 << i;
         tick(3);
         req(1'b1, vecTab[i], "peripheral vector");
      end
      periphIrq <= 7'h7f;
      wr(IDX_PC_CTRL, 8'h01);
      tick(3);
      req(1'b1, VEC_PIN_CHANGE, "lowest pending first");
      wr(IDX_PC_FLAG, 8'h01);
      tick(2);
      req(1'b1, vecTab[0], "next lowest");
      periphIrq <= 7'h0;
      tally_and_finish;
   end
endmodule // interrupt_reset_source_unit_tb
